/* File: design/lane_pkg.sv */
// Shared constants, types and decode functions for byte-lane steering
package lane_pkg;

  // Access sizes issued by the processor side
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10,
    SZ_QUAD = 2'b11
  } size_type;

  // Sequencer states, Gray coded along idle, first cycle, second cycle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b11
  } state_type;

  localparam int       LANES         = 8;
  localparam logic [2:0] HIGH_HALF_OFF = 3'h4;
  localparam logic [7:0] STRB_NONE     = 8'h00;
  localparam logic [7:0] STRB_NARROW   = 8'h0F;
  localparam logic [7:0] STRB_ALL      = 8'hFF;
  localparam logic [63:0] DATA_RST     = 64'h0000_0000_0000_0000;
  localparam logic [2:0] OFF_RST       = 3'h0;
  localparam int       SYNC_STAGES   = 2;

  // Lanes covered by an access of the given size, starting at lane 0
  function automatic logic [7:0] size_mask(input logic [1:0] size);
    case (size)
      SZ_BYTE: size_mask = 8'h01;
      SZ_WORD: size_mask = 8'h03;
      SZ_LONG: size_mask = 8'h0F;
      default: size_mask = 8'hFF;
    endcase
  endfunction : size_mask

  // Offset forced onto the natural boundary of the size and device width
  function automatic logic [2:0] align_off(input logic [1:0] size,
                                           input logic [2:0] off,
                                           input logic       wide);
    logic [2:0] a;
    case (size)
      SZ_BYTE: a = off;
      SZ_WORD: a = {off[2:1], 1'b0};
      SZ_LONG: a = {off[2], 2'b00};
      default: a = 3'h0;
    endcase
    align_off = wide ? a : {1'b0, a[1:0]};
  endfunction : align_off

endpackage : lane_pkg

/* File: design/lane_map.sv */
// Combinational lane map: strobes, write lanes and read extraction
module lane_map
  import lane_pkg::*;
(
  input  wire logic [1:0]  size,    // Access size
  input  wire logic [2:0]  off,     // Byte offset in the eight-byte unit
  input  wire logic        wide,    // High for a 64-bit device
  input  wire logic        phase,   // Second cycle of a split quadword
  input  wire logic [63:0] wdata,   // Processor write data, right aligned
  input  wire logic [63:0] rlanes,  // Lanes read back from the bus
  output logic      [7:0]  strobe,  // Lane strobes, high means asserted
  output logic      [63:0] lanes,   // Write data placed on its lanes
  output logic      [63:0] rdata    // Read data, right aligned
);

  logic [2:0]  eff;
  logic [5:0]  shamt;
  logic [7:0]  bmask;
  logic [63:0] dmask;
  logic        split;

  assign eff   = align_off(size, off, wide);
  assign shamt = {eff, 3'b000};
  assign bmask = size_mask(size);
  assign split = (size == SZ_QUAD) && !wide;

  // Byte mask widened to a bit mask
  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_mask
      assign dmask[i*8 +: 8] = {8{bmask[i]}};
    end
  endgenerate

  // Steering for both directions; unused lanes are zero
  always_comb begin
    if (split) begin
      strobe = STRB_NARROW;
      lanes  = phase ? {32'h0000_0000, wdata[63:32]} : {32'h0000_0000, wdata[31:0]};
      rdata  = phase ? {rlanes[31:0], 32'h0000_0000} : {32'h0000_0000, rlanes[31:0]};
    end else begin
      strobe = (bmask << eff) & (wide ? STRB_ALL : STRB_NARROW);
      lanes  = (wdata & dmask) << shamt;
      rdata  = (rlanes >> shamt) & dmask;
    end
  end

endmodule : lane_map

/* File: design/le_byte_lane_steering.sv */
// Little-endian byte-lane steering and strobe sequencing for the memory bus
//
// Notes on behaviour
// - On a 64-bit device a byte at offset k goes on lane k in one cycle with only strobe k.
// - On a 64-bit device a word at offset 2m uses lanes 2m and 2m+1 in one cycle, low byte low.
// - On a 64-bit device a longword uses lanes 0-3 or 4-7 and a quadword all lanes, one cycle.
// - On a 32-bit device a byte at offset k of four goes on lane k in one cycle with strobe k.
// - On a 32-bit device a word uses lanes 0-1 or 2-3 and a longword all four lanes, one cycle.
// - On a 32-bit device a quadword takes two cycles, low half at base then high half at base+4.
module le_byte_lane_steering
  import lane_pkg::*;
(
  input  wire logic        clk,         // Bus clock
  input  wire logic        nrst,        // Asynchronous reset, active low
  input  wire logic        wide,        // High selects a 64-bit device, low 32-bit
  input  wire logic        req_valid,   // Processor access request
  output logic             req_ready,   // Sequencer can take a request
  input  wire logic        req_write,   // High for a write
  input  wire logic [1:0]  req_size,    // Access size
  input  wire logic [2:0]  req_off,     // Byte offset within eight bytes
  input  wire logic [63:0] req_wdata,   // Write data, right aligned
  output logic             bus_cyc,     // Bus cycle active
  output logic             bus_write,   // Bus cycle is a write
  output logic [2:0]       bus_off,     // Low address bits of the cycle
  output logic [7:0]       bus_strobe,  // Lane strobes, high means asserted
  output logic [63:0]      bus_wdata,   // Data lanes driven on a write
  input  wire logic [63:0] bus_rdata,   // Data lanes from the pins
  output logic             resp_valid,  // Read data ready, one cycle
  output logic [63:0]      resp_rdata   // Read data, right aligned
);

  state_type   state_reg, state_next;
  logic [1:0]  size_reg;
  logic [2:0]  off_reg;
  logic        wide_reg;
  logic        write_reg;
  logic [63:0] data_reg;
  logic        phase_reg;
  logic        last_reg;
  logic        accept;
  logic        split;
  logic [1:0]  map_size;
  logic [2:0]  map_off;
  logic        map_wide;
  logic        map_phase;
  logic [63:0] map_wdata;
  logic [7:0]  map_strobe;
  logic [63:0] map_lanes;
  logic [63:0] rd_sync1_reg, rd_sync2_reg;
  logic [8:0]  ctx1_reg, ctx2_reg;
  logic [63:0] rd_ext;
  logic [63:0] acc_reg;

  assign accept = (state_reg == ST_IDLE) && req_valid;
  assign split  = (size_reg == SZ_QUAD) && !wide_reg;

  // Next state of the access sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          state_next = ST_LOW;
        end
      end
      ST_LOW: begin
        state_next = split ? ST_HIGH : ST_IDLE;
      end
      ST_HIGH: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer state and ready flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      req_ready <= 1'b1;
    end else begin
      state_reg <= state_next;
      req_ready <= (state_next == ST_IDLE);
    end
  end

  // Access context captured at acceptance
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      size_reg  <= SZ_BYTE;
      off_reg   <= OFF_RST;
      wide_reg  <= 1'b0;
      write_reg <= 1'b0;
      data_reg  <= DATA_RST;
    end else if (accept) begin
      size_reg  <= req_size;
      off_reg   <= req_off;
      wide_reg  <= wide;
      write_reg <= req_write;
      data_reg  <= req_wdata;
    end
  end

  // Lane map inputs for the cycle about to be driven
  assign map_size  = (state_reg == ST_IDLE) ? req_size : size_reg;
  assign map_off   = (state_reg == ST_IDLE) ? req_off : off_reg;
  assign map_wide  = (state_reg == ST_IDLE) ? wide : wide_reg;
  assign map_wdata = (state_reg == ST_IDLE) ? req_wdata : data_reg;
  assign map_phase = (state_reg == ST_LOW);

  lane_map u_issue_map (
    .size   (map_size),
    .off    (map_off),
    .wide   (map_wide),
    .phase  (map_phase),
    .wdata  (map_wdata),
    .rlanes (DATA_RST),
    .strobe (map_strobe),
    .lanes  (map_lanes),
    .rdata  ()
  );

  // idle lanes and strobes held at zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_cyc    <= 1'b0;
      bus_write  <= 1'b0;
      bus_off    <= OFF_RST;
      bus_strobe <= STRB_NONE;
      bus_wdata  <= DATA_RST;
      phase_reg  <= 1'b0;
      last_reg   <= 1'b0;
    end else if (accept || (state_reg == ST_LOW && split)) begin
      bus_cyc    <= 1'b1;
      bus_write  <= (state_reg == ST_IDLE) ? req_write : write_reg;
      bus_off    <= map_phase ? HIGH_HALF_OFF : align_off(map_size, map_off, map_wide);
      bus_strobe <= map_strobe;
      bus_wdata  <= ((state_reg == ST_IDLE) ? req_write : write_reg) ? map_lanes : DATA_RST;
      phase_reg  <= map_phase;
      last_reg   <= map_phase || !((map_size == SZ_QUAD) && !map_wide);
    end else begin
      bus_cyc    <= 1'b0;
      bus_write  <= 1'b0;
      bus_off    <= OFF_RST;
      bus_strobe <= STRB_NONE;
      bus_wdata  <= DATA_RST;
      phase_reg  <= 1'b0;
      last_reg   <= 1'b0;
    end
  end

  // Read lanes pass two flip-flops before use; context follows alongside
  // The offset travels with the context, since a following access may
  // already have replaced the captured one when the read data returns
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_sync1_reg <= DATA_RST;
      rd_sync2_reg <= DATA_RST;
      ctx1_reg     <= 9'h000;
      ctx2_reg     <= 9'h000;
    end else begin
      rd_sync1_reg <= bus_rdata;
      rd_sync2_reg <= rd_sync1_reg;
      ctx1_reg     <= {bus_cyc && !bus_write, last_reg, phase_reg, wide_reg, size_reg, off_reg};
      ctx2_reg     <= ctx1_reg;
    end
  end

  lane_map u_return_map (
    .size   (ctx2_reg[4:3]),
    .off    (ctx2_reg[2:0]),
    .wide   (ctx2_reg[5]),
    .phase  (ctx2_reg[6]),
    .wdata  (DATA_RST),
    .rlanes (rd_sync2_reg),
    .strobe (),
    .lanes  (),
    .rdata  (rd_ext)
  );

  // read halves gathered low then high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg    <= DATA_RST;
      resp_valid <= 1'b0;
      resp_rdata <= DATA_RST;
    end else begin
      if (ctx2_reg[8] && !ctx2_reg[6]) begin
        acc_reg <= rd_ext;
      end
      resp_valid <= ctx2_reg[8] && ctx2_reg[7];
      if (ctx2_reg[8] && ctx2_reg[7]) begin
        resp_rdata <= ctx2_reg[6] ? (acc_reg | rd_ext) : rd_ext;
      end
    end
  end

  a_byte_lane_wide: assert property (@(posedge clk) disable iff (!nrst)
    bus_cyc && wide_reg && size_reg == SZ_BYTE |-> bus_strobe == (8'h01 << bus_off)
      && bus_off == off_reg && !$past(bus_cyc))
    else $error("byte on 64-bit device misplaced");

  a_word_lane_wide: assert property (@(posedge clk) disable iff (!nrst)
    bus_cyc && wide_reg && size_reg == SZ_WORD && bus_write |-> bus_strobe == (8'h03 << bus_off)
      && !bus_off[0] && bus_wdata[bus_off*8 +: 16] == data_reg[15:0])
    else $error("word on 64-bit device misplaced");

  a_long_quad_wide: assert property (@(posedge clk) disable iff (!nrst)
    bus_cyc && wide_reg && size_reg[1] |-> (size_reg == SZ_QUAD ? bus_strobe == STRB_ALL
      : bus_strobe == (8'h0F << {off_reg[2], 2'b00})) ##1 !bus_cyc)
    else $error("long or quad on 64-bit device wrong");

  a_byte_lane_narrow: assert property (@(posedge clk) disable iff (!nrst)
    bus_cyc && !wide_reg && size_reg == SZ_BYTE |-> bus_strobe == (8'h01 << off_reg[1:0])
      && bus_strobe[7:4] == 4'h0)
    else $error("byte on 32-bit device misplaced");

  a_word_long_narrow: assert property (@(posedge clk) disable iff (!nrst)
    bus_cyc && !wide_reg && (size_reg == SZ_WORD || size_reg == SZ_LONG) |->
      bus_strobe == (size_reg == SZ_LONG ? STRB_NARROW : (8'h03 << {off_reg[1], 1'b0}))
      ##1 !bus_cyc)
    else $error("word or long on 32-bit device wrong");

  a_quad_split_narrow: assert property (@(posedge clk) disable iff (!nrst)
    bus_cyc && !wide_reg && size_reg == SZ_QUAD && !phase_reg && bus_write |->
      bus_strobe == STRB_NARROW && bus_off == 3'h0 && bus_wdata[31:0] == data_reg[31:0]
      ##1 bus_cyc && bus_strobe == STRB_NARROW && bus_off == HIGH_HALF_OFF
      && bus_wdata[31:0] == data_reg[63:32] ##1 !bus_cyc)
    else $error("quad on 32-bit device not split");

  a_idle_lanes_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (!bus_cyc |-> bus_strobe == STRB_NONE && bus_wdata == DATA_RST) and
    (bus_cyc && !wide_reg |-> bus_strobe[7:4] == 4'h0 && bus_wdata[63:32] == 32'h0000_0000))
    else $error("unused lane driven");

  a_accept_to_cycle: assert property (@(posedge clk) disable iff (!nrst)
    req_valid && req_ready |=> bus_cyc && !req_ready)
    else $error("accepted request not issued next cycle");

endmodule : le_byte_lane_steering

/* File: verif/lane_device_model.sv */
// Memory device model on the far side of the steered data lanes
module lane_device_model
  import lane_pkg::*;
(
  input  wire logic        clk,         // Bus clock
  input  wire logic        wide,        // High for a 64-bit device
  input  wire logic        bus_cyc,     // Bus cycle active
  input  wire logic        bus_write,   // Bus cycle is a write
  input  wire logic [2:0]  bus_off,     // Low address bits of the cycle
  input  wire logic [7:0]  bus_strobe,  // Lane strobes
  input  wire logic [63:0] bus_wdata,   // Lanes written
  output logic      [63:0] bus_rdata    // Lanes read back
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem_reg [8] = '{default: 8'h00};
  logic [63:0] lane_val;

  // Store only the lanes whose strobe is asserted
  // unstrobed lanes ignored
  always @(posedge clk) begin
    if (bus_cyc && bus_write) begin
      for (int i = 0; i < 8; i++) begin
        if (bus_strobe[i]) begin
          mem_reg[wide ? 3'(i) : {bus_off[2], 2'(i)}] <= bus_wdata[8*i +: 8];
        end
      end
    end
  end

  // Upper lanes of a narrow device and released lanes carry junk
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lane_val[8*i +: 8] = mem_reg[wide ? 3'(i) : {bus_off[2], 2'(i)}];
      if (!wide && i > 3) begin
        lane_val[8*i +: 8] = ~lane_val[8*i +: 8];
      end
    end
  end
  assign bus_rdata = (bus_cyc && !bus_write) ? lane_val : ~lane_val;
endmodule : lane_device_model

/* File: verif/le_byte_lane_steering_bench.sv */
// Self-checking bench for the little-endian lane steering block
module le_byte_lane_steering_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lane_pkg::*;
  logic        clk, nrst, wide, req_valid, req_ready, req_write;
  logic [1:0]  req_size;
  logic [2:0]  req_off, bus_off;
  logic [63:0] req_wdata, bus_wdata, bus_rdata, resp_rdata;
  logic        bus_cyc, bus_write, resp_valid;
  logic [7:0]  bus_strobe;
  int          err_count = 0;
  int          n_compared = 0;

  le_byte_lane_steering le_byte_lane_steering_i (
    .clk(clk), .nrst(nrst), .wide(wide), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_size(req_size), .req_off(req_off), .req_wdata(req_wdata),
    .bus_cyc(bus_cyc), .bus_write(bus_write), .bus_off(bus_off), .bus_strobe(bus_strobe),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata));
  lane_device_model lane_device_model_i (
    .clk(clk), .wide(wide), .bus_cyc(bus_cyc), .bus_write(bus_write), .bus_off(bus_off),
    .bus_strobe(bus_strobe), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

  // Free-running bus clock
  always #5 clk = ~clk;

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One access, judged cycle by cycle against the lane tables
  task automatic run_access(input logic w, input logic [1:0] sz, input logic [2:0] off,
                            input logic [63:0] d);
    logic [2:0]  aoff;
    logic [7:0]  smask;
    logic [63:0] dm;
    int          n;
    aoff = (sz == 2'd3) ? 3'h0 : off & ~3'((1 << sz) - 1);
    if (!wide) aoff[2] = 1'b0;
    smask = 8'((9'h1 << (1 << sz)) - 1);
    dm = (sz == 2'd3) ? d : d & ((64'h1 << (8 << sz)) - 1);
    @(negedge clk);
    {req_valid, req_write, req_size, req_off, req_wdata} = {1'b1, w, sz, off, d};
    @(negedge clk);
    req_valid = 1'b0;
    if (!wide && sz == 2'd3) begin
      // low half at base, high half at base plus four
      chk({bus_cyc, bus_write, bus_off, bus_strobe}, {1'b1, w, 3'h0, 8'h0f});
      chk(bus_wdata, w ? {32'h0, d[31:0]} : 64'h0);
      @(negedge clk);
      chk({bus_cyc, bus_write, bus_off, bus_strobe}, {1'b1, w, 3'h4, 8'h0f});
      chk(bus_wdata, w ? {32'h0, d[63:32]} : 64'h0);
    end else begin
      chk({bus_cyc, bus_write, bus_off, bus_strobe}, {1'b1, w, aoff, 8'(smask << aoff)});
      chk(bus_wdata, w ? dm << (8 * aoff) : 64'h0);
    end
    @(negedge clk);
    // strobes negated once the access is over
    chk({req_ready, bus_cyc, bus_strobe}, {1'b1, 1'b0, 8'h00});
    if (!w) begin
      n = 1;
      while (resp_valid !== 1'b1 && n < 10) begin
        @(negedge clk);
        n++;
      end
      chk(64'(n), 64'd3);
      if (n >= 10) finish_test();
      chk(resp_rdata, dm);
    end
  endtask : run_access

  // Every size at every offset on both device widths, write then read back
  task automatic scen_map;
    for (int w = 1; w >= 0; w--) begin
      for (int s = 0; s < 4; s++) begin
        for (int o = 0; o < 8; o++) begin
          wide = w[0];
          run_access(1'b1, 2'(s), 3'(o), 64'hf7e6_d5c4_b3a2_9180 + 64'(o * 9 + s));
          run_access(1'b0, 2'(s), 3'(o), 64'hf7e6_d5c4_b3a2_9180 + 64'(o * 9 + s));
        end
      end
    end
  endtask : scen_map

  // A request held over the busy cycle is ignored, not queued
  task automatic scen_refuse;
    wide = 1'b1;
    @(negedge clk);
    {req_valid, req_write, req_size, req_off, req_wdata} = {1'b1, 1'b1, SZ_BYTE, 3'h7, 64'h5a};
    @(negedge clk);
    chk({bus_cyc, bus_strobe, bus_wdata[63:56]}, {1'b1, 8'h80, 8'h5a});
    @(negedge clk);
    req_valid = 1'b0;
    // no second cycle from the refused request
    chk({bus_cyc, bus_strobe}, 9'h000);
    @(negedge clk);
    chk({bus_cyc, bus_strobe}, 9'h000);
  endtask : scen_refuse

  // Two reads two edges apart answer in order, each with its own offset
  task automatic scen_pipe;
    logic [63:0] q;
    q = 64'h0123_4567_89ab_cdef;
    wide = 1'b1;
    run_access(1'b1, SZ_QUAD, 3'h0, q);
    {req_valid, req_write, req_size, req_off} = {1'b1, 1'b0, SZ_BYTE, 3'h5};
    @(negedge clk);
    req_valid = 1'b0;
    chk({bus_cyc, bus_off, bus_strobe}, {1'b1, 3'h5, 8'h20});
    @(negedge clk);
    {req_valid, req_off} = {1'b1, 3'h2};
    @(negedge clk);
    req_valid = 1'b0;
    chk({bus_cyc, bus_off, bus_strobe}, {1'b1, 3'h2, 8'h04});
    @(negedge clk);
    chk(64'(resp_valid), 64'h1);
    chk(resp_rdata, {56'h0, q[47:40]});
    @(negedge clk);
    chk(64'(resp_valid), 64'h0);
    @(negedge clk);
    chk(64'(resp_valid), 64'h1);
    chk(resp_rdata, {56'h0, q[23:16]});
  endtask : scen_pipe

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    wide = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_size = SZ_BYTE;
    req_off = 3'h0;
    req_wdata = 64'h0000_0000_0000_0000;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    scen_map();
    scen_refuse();
    scen_pipe();
    finish_test();
  end
endmodule : le_byte_lane_steering_bench
